// file: design/lowside_fault_diag_protect.sv
// Per-channel fault diagnostics, diagnostic pulses and shorted-load protection.
`timescale 1ns/100ps
`default_nettype none
`include "fault_diag_consts.svh"
module lowside_fault_diag_protect #(
  parameter int CH = 6,
  parameter int BLANK_W = 12,
  parameter int FILT_W = 10,
  parameter int RETRY_W = 20,
  parameter int RETRY_CYC = `FAULT_RETRY_TIME_NS / `CLK_PERIOD_NS
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Pins from the outside world.
  input wire logic master_reset_n_i,
  input wire logic global_disable_in_i,
  input wire logic chip_select_n_i,
  input wire logic [CH-1:0] parallel_in_i,
  // Drain feedback comparator results.
  input wire logic [CH-1:0] drain_feedback_short_i,
  input wire logic [CH-1:0] drain_feedback_ground_i,
  input wire logic [CH-1:0] drain_feedback_open_i,
  // Configuration bits.
  input wire logic [CH-1:0] gate_command_i,
  input wire logic [CH-1:0] recovery_mode_select_i,
  input wire logic [CH-1:0] open_load_diag_enable_i,
  input wire logic [CH-1:0] fast_charge_enable_i,
  input wire logic [4*CH-1:0] blanking_time_select_i,
  input wire logic [3*CH-1:0] short_threshold_select_i,
  // Diagnostic pulse requests and status read strobes.
  input wire logic [CH-1:0] off_pulse_request_i,
  input wire logic [CH-1:0] on_pulse_request_i,
  input wire logic [1:0] status_read_i,
  // Outputs.
  output logic [CH-1:0] gate_drive_out_o,
  output logic [CH-1:0] fast_charge_current_o,
  output logic [CH-1:0] open_load_active_o,
  output logic [3*CH-1:0] short_threshold_select_o,
  output logic [3*CH-1:0] status_o,
  output logic fault_flag_n_o,
  output logic fault_flag_oe_n_o
);
  import fault_diag_pkg::*;

  localparam int BLANK_STEP_CYC = (`BLANK_STEP_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int FILT_CYC = (`FAULT_FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  // Chip select idles high, so the synchroniser starts there and no false edge follows reset.
  localparam logic [`SYNC_WIDTH-1:0] SYNC_IDLE = `SYNC_WIDTH'(1) << `SYNC_CS;

  logic [`SYNC_WIDTH-1:0] s1_reg, s2_reg, s3_reg, sync_reg, sync_next;
  logic en_prev_reg, cs_prev_reg, flag_reg, flag_next;
  logic [CH-1:0] gate_reg, gate_next, shrt_reg, shrt_next, hold_reg, hold_next;
  logic [CH-1:0] pulse_reg, pulse_next, poff_reg, poff_next, plvl_reg, plvl_next;
  logic [CH-1:0] cmp_reg, cmp_next, fc_reg, fc_next, ol_reg, ol_next;
  logic [BLANK_W-1:0] blank_reg [CH];
  logic [BLANK_W-1:0] blank_next [CH];
  logic [FILT_W-1:0] filt_reg [CH];
  logic [FILT_W-1:0] filt_next [CH];
  status_type status_reg [CH];
  status_type status_next [CH];
  logic [RETRY_W-1:0] retry_reg, retry_next;
  logic [3*CH-1:0] thr_reg;
  logic en, en_rise, cs_rise;
  logic [CH-1:0] clr, smp, pulse_ok;

  function automatic logic [BLANK_W-1:0] blank_count(input logic [3:0] sel);
    blank_count = BLANK_W'((int'(sel) + 1) * BLANK_STEP_CYC);
  endfunction

  function automatic status_type sample_code(input logic on, input logic sh, input logic gnd,
                                             input logic opn, input logic ol_en);
    if (on) begin
      sample_code = sh ? ST_SHORTED_LOAD : ST_ON_NO_SHORT;
    end else if (gnd) begin
      sample_code = ST_GROUND_SHORT;
    end else if (opn && ol_en) begin
      sample_code = ST_OPEN_LOAD;
    end else begin
      sample_code = ST_OFF_NO_FAULT;
    end
  endfunction

  assign en = sync_reg[`SYNC_MRST] & ~sync_reg[`SYNC_DIS];
  assign en_rise = en & ~en_prev_reg;
  assign cs_rise = sync_reg[`SYNC_CS] & ~cs_prev_reg;

  always_comb begin
    for (int b = 0; b < `SYNC_WIDTH; b++) begin
      sync_next[b] = (s2_reg[b] == s3_reg[b]) ? s3_reg[b] : sync_reg[b];
    end
  end

  always_comb begin
    logic cmd, drive, lvl, ol_en, sh, gnd, opn;
    status_type code, base;
    cmd = 1'b0;
    drive = 1'b0;
    lvl = 1'b0;
    ol_en = 1'b0;
    sh = 1'b0;
    gnd = 1'b0;
    opn = 1'b0;
    code = ST_NOT_COMPLETE;
    base = ST_NOT_COMPLETE;
    flag_next = 1'b0;
    clr = '0;
    smp = '0;
    pulse_ok = '0;
    retry_next = retry_reg;
    for (int i = 0; i < CH; i++) begin
      sh = sync_reg[`SYNC_SHORT + i];
      gnd = sync_reg[`SYNC_GND + i];
      opn = sync_reg[`SYNC_OPEN + i];
      cmd = sync_reg[`SYNC_PAR + i] | gate_command_i[i];
      hold_next[i] = hold_reg[i] & en & recovery_mode_select_i[i] & (retry_reg != RETRY_W'(1));
      shrt_next[i] = shrt_reg[i] & ~en_rise;
      pulse_next[i] = pulse_reg[i] & en & (blank_reg[i] != BLANK_W'(1));
      poff_next[i] = poff_reg[i];
      plvl_next[i] = plvl_reg[i];
      pulse_ok[i] = cs_rise & en & (on_pulse_request_i[i] ^ off_pulse_request_i[i])
                    & (status_reg[i] != ST_SHORTED_LOAD) & ~pulse_reg[i]
                    & (blank_reg[i] == '0) & ~hold_reg[i];
      if (pulse_ok[i]) begin
        pulse_next[i] = 1'b1;
        poff_next[i] = off_pulse_request_i[i];
        plvl_next[i] = ~gate_reg[i];
        shrt_next[i] = 1'b0;
      end
      drive = en & ~shrt_next[i] & ~hold_next[i] & cmd;
      lvl = pulse_next[i] ? plvl_next[i] : drive;
      gate_next[i] = lvl;
      if (en_rise || (lvl != gate_reg[i])) begin
        blank_next[i] = blank_count(blanking_time_select_i[4*i +: 4]);
      end else if (blank_reg[i] != '0) begin
        blank_next[i] = blank_reg[i] - BLANK_W'(1);
      end else begin
        blank_next[i] = '0;
      end
      ol_en = open_load_diag_enable_i[i] | (pulse_reg[i] & poff_reg[i]);
      ol_next[i] = en & ~gate_reg[i] & ol_en;
      fc_next[i] = en & ~gate_reg[i] & ol_en & fast_charge_enable_i[i] & (blank_reg[i] != '0);
      cmp_next[i] = gate_reg[i] ? sh : (gnd | (opn & ol_en));
      if (!en) begin
        filt_next[i] = '0;
      end else if ((cmp_next[i] != cmp_reg[i]) && (filt_reg[i] == '0)) begin
        filt_next[i] = FILT_W'(FILT_CYC);
      end else if (filt_reg[i] != '0) begin
        filt_next[i] = filt_reg[i] - FILT_W'(1);
      end else begin
        filt_next[i] = '0;
      end
      smp[i] = en & ((blank_reg[i] == BLANK_W'(1)) | (filt_reg[i] == FILT_W'(1)));
      code = sample_code(gate_reg[i], sh, gnd, opn, ol_en);
      clr[i] = status_read_i[i / `CH_PER_READ] | ~sync_reg[`SYNC_MRST];
      base = clr[i] ? ST_NOT_COMPLETE : status_reg[i];
      status_next[i] = (smp[i] && (code < base)) ? code : base;
      if (smp[i] && code == ST_SHORTED_LOAD) begin
        if (recovery_mode_select_i[i]) begin
          hold_next[i] = 1'b1;
          if (retry_reg <= RETRY_W'(1)) begin
            retry_next = RETRY_W'(RETRY_CYC);
          end
        end else begin
          shrt_next[i] = 1'b1;
        end
      end
      if (status_next[i] inside {ST_SHORTED_LOAD, ST_GROUND_SHORT, ST_OPEN_LOAD}) begin
        flag_next = 1'b1;
      end
    end
    if (!en || hold_next == '0) begin
      retry_next = '0;
    end else if (retry_reg != '0 && retry_next == retry_reg) begin
      retry_next = retry_reg - RETRY_W'(1);
    end
    flag_next = flag_next & en & sync_reg[`SYNC_CS];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_reg <= SYNC_IDLE;
      s2_reg <= SYNC_IDLE;
      s3_reg <= SYNC_IDLE;
      sync_reg <= SYNC_IDLE;
      en_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
      flag_reg <= 1'b0;
      gate_reg <= '0;
      shrt_reg <= '0;
      hold_reg <= '0;
      pulse_reg <= '0;
      poff_reg <= '0;
      plvl_reg <= '0;
      cmp_reg <= '0;
      fc_reg <= '0;
      ol_reg <= '0;
      retry_reg <= '0;
      thr_reg <= '0;
      for (int i = 0; i < CH; i++) begin
        blank_reg[i] <= '0;
        filt_reg[i] <= '0;
        status_reg[i] <= ST_NOT_COMPLETE;
      end
    end else begin
      s1_reg <= {drain_feedback_open_i, drain_feedback_ground_i, drain_feedback_short_i,
                 parallel_in_i, chip_select_n_i, global_disable_in_i, master_reset_n_i};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_reg <= sync_next;
      en_prev_reg <= en;
      cs_prev_reg <= sync_reg[`SYNC_CS];
      flag_reg <= flag_next;
      gate_reg <= gate_next;
      shrt_reg <= shrt_next;
      hold_reg <= hold_next;
      pulse_reg <= pulse_next;
      poff_reg <= poff_next;
      plvl_reg <= plvl_next;
      cmp_reg <= cmp_next;
      fc_reg <= fc_next;
      ol_reg <= ol_next;
      retry_reg <= retry_next;
      thr_reg <= short_threshold_select_i;
      for (int i = 0; i < CH; i++) begin
        blank_reg[i] <= blank_next[i];
        filt_reg[i] <= filt_next[i];
        status_reg[i] <= status_next[i];
      end
    end
  end

  always_comb begin
    for (int i = 0; i < CH; i++) begin
      status_o[3*i +: 3] = status_reg[i];
    end
  end

  assign gate_drive_out_o = gate_reg;
  assign fast_charge_current_o = fc_reg;
  assign open_load_active_o = ol_reg;
  assign short_threshold_select_o = thr_reg;
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_oe_n_o = ~flag_reg;

  // Checks on the protection and diagnostic behaviour.
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  gate_off_disabled_a: assert property (
    !en |=> gate_drive_out_o == '0) else $error("Gate driven while disabled.");
  blank_on_change_a: assert property (
    (gate_reg[0] != $past(gate_reg[0])) |-> blank_reg[0] != '0)
    else $error("Gate changed without blanking.");
  no_demote_a: assert property (
    (status_reg[0] > $past(status_reg[0])) |-> $past(clr[0]))
    else $error("Status demoted without a clear.");
  reset_clears_a: assert property (
    !sync_reg[`SYNC_MRST] ##1 !smp[0] |-> status_reg[0] == ST_NOT_COMPLETE)
    else $error("Reset input did not clear status.");
  latch_off_a: assert property (
    (shrt_reg & $past(shrt_reg) & ~pulse_reg & gate_reg) == '0)
    else $error("Latched channel is on.");
  retry_hold_a: assert property (
    (hold_reg & $past(hold_reg) & ~pulse_reg & gate_reg) == '0
      && (hold_reg == '0 || retry_reg != '0))
    else $error("Retry hold let gate on.");
  pulse_disabled_a: assert property (
    !en |=> pulse_reg == '0) else $error("Pulse running while disabled.");
  diag_suspend_a: assert property (
    !en |=> filt_reg[0] == '0 && !fault_flag_oe_n_o == 1'b0)
    else $error("Diagnostics active while disabled.");
  pulse_toggle_a: assert property (
    (pulse_ok != '0) |=> (pulse_reg & $past(pulse_ok)) == $past(pulse_ok)
      && ((gate_reg ^ $past(gate_reg)) & $past(pulse_ok)) == $past(pulse_ok))
    else $error("Pulse did not toggle output.");

  pulse_run_c: cover property ((pulse_ok != '0) ##1 (pulse_reg != '0) [*2]);
  pulse_end_c: cover property ((pulse_reg != '0) ##1 (pulse_reg == '0) && en);
  latch_short_c: cover property ((shrt_reg == '0) ##1 (shrt_reg != '0));
  retry_done_c: cover property ((hold_reg != '0) ##1 (hold_reg == '0) && en);
endmodule
`default_nettype wire

// file: design/fault_diag_consts.svh
// Timing and layout constants for the low-side fault diagnostic block.
`ifndef FAULT_DIAG_CONSTS_SVH
`define FAULT_DIAG_CONSTS_SVH
`define CLK_PERIOD_NS 100
`define BLANK_STEP_TIME_NS 16000
`define FAULT_FILTER_TIME_NS 10000
`define FAULT_RETRY_TIME_NS 10000000
`define SYNC_WIDTH 27
`define SYNC_MRST 0
`define SYNC_DIS 1
`define SYNC_CS 2
`define SYNC_PAR 3
`define SYNC_SHORT 9
`define SYNC_GND 15
`define SYNC_OPEN 21
`define CH_PER_READ 3
`endif

// file: design/fault_diag_pkg.sv
// Types shared by the low-side fault diagnostic block.
package fault_diag_pkg;
  typedef enum logic [2:0] {
    ST_INVALID = 3'h0,
    ST_SHORTED_LOAD = 3'h1,
    ST_GROUND_SHORT = 3'h2,
    ST_OPEN_LOAD = 3'h3,
    ST_COMPLETE_OK = 3'h4,
    ST_ON_NO_SHORT = 3'h5,
    ST_OFF_NO_FAULT = 3'h6,
    ST_NOT_COMPLETE = 3'h7
  } status_type;
endpackage

// file: verif/drain_model.sv
// Drain comparator model for the six external MOSFETs and their loads.
`timescale 1ns/100ps
`default_nettype none
module drain_model (
  // Gate levels and injected faults.
  input wire logic [5:0] gate_i,
  input wire logic [5:0] short_flt_i,
  input wire logic [5:0] gnd_flt_i,
  input wire logic [5:0] open_flt_i,
  // Comparator results.
  output logic [5:0] short_o,
  output logic [5:0] gnd_o,
  output logic [5:0] open_o
);
  // A shorted load only shows while the gate is on.
  assign short_o = gate_i & short_flt_i;
  // The off-state window reports ground short ahead of open load.
  assign gnd_o = ~gate_i & gnd_flt_i;
  assign open_o = ~gate_i & open_flt_i & ~gnd_flt_i;
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking bench for the fault diagnostic block.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import fault_diag_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic mrst_n = 1'b1;
  logic dis = 1'b0;
  logic cs_n = 1'b1;
  logic [5:0] par = 6'h00, gcmd = 6'h00, rmode = 6'h00, ol_en = 6'h3F, fc_en = 6'h3F;
  logic [5:0] offp = 6'h00, onp = 6'h00, sflt = 6'h02, gflt = 6'h04, oflt = 6'h00;
  logic [1:0] rd = 2'h0;
  logic [23:0] blank = 24'h000000;
  logic [17:0] thr = 18'h00000;
  logic [5:0] gate, sh, gn, op;
  logic [17:0] st;
  logic fl_oe_n;
  int n_mismatch = 0;
  int checks = 0;
  always #50 clk_i = ~clk_i;
  lowside_fault_diag_protect #(.RETRY_CYC(50)) lowside_fault_diag_protect_i (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .master_reset_n_i(mrst_n),
    .global_disable_in_i(dis), .chip_select_n_i(cs_n), .parallel_in_i(par),
    .drain_feedback_short_i(sh), .drain_feedback_ground_i(gn), .drain_feedback_open_i(op),
    .gate_command_i(gcmd), .recovery_mode_select_i(rmode), .open_load_diag_enable_i(ol_en),
    .fast_charge_enable_i(fc_en), .blanking_time_select_i(blank),
    .short_threshold_select_i(thr), .off_pulse_request_i(offp), .on_pulse_request_i(onp),
    .status_read_i(rd), .gate_drive_out_o(gate), .fast_charge_current_o(),
    .open_load_active_o(), .short_threshold_select_o(), .status_o(st),
    .fault_flag_n_o(), .fault_flag_oe_n_o(fl_oe_n));
  drain_model drain_model_i (.gate_i(gate), .short_flt_i(sflt), .gnd_flt_i(gflt),
    .open_flt_i(oflt), .short_o(sh), .gnd_o(gn), .open_o(op));
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #10;
  endtask
  task automatic conclude;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [17:0] exp, input logic [17:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  function automatic logic [2:0] cur(input bit g, input int ch);
    return g ? {2'b00, gate[ch]} : st[3*ch+:3];
  endfunction
  // Waits a bounded time for a gate (g set) or a status field to reach a value.
  task automatic wait_for(input bit g, input int ch, input logic [2:0] exp);
    int k;
    k = 0;
    while (cur(g, ch) !== exp && k < 400) begin
      step(1);
      k++;
    end
    cmp(g ? "awaited gate" : "awaited status", exp, cur(g, ch));
    if (k >= 400) conclude();
  endtask
  task automatic pulse(input logic [5:0] m);
    cs_n = 1'b0;
    onp = m;
    step(6);
    cs_n = 1'b1;
    step(8);
    onp = 6'h00;
  endtask
  task automatic t_start;
    cmp("status at reset", 18'h3FFFF, st);
    cmp("gates at reset", 18'h00000, gate);
    wait_for(0, 0, ST_OFF_NO_FAULT);
    step(2);
    cmp("ch1 status", ST_OFF_NO_FAULT, st[5:3]);
    cmp("ch2 status", ST_GROUND_SHORT, st[8:6]);
    cmp("flag enable", 1'b0, fl_oe_n);
  endtask
  task automatic t_priority;
    gflt = 6'h00;
    step(150);
    cmp("ch2 kept over no fault", ST_GROUND_SHORT, st[8:6]);
    oflt = 6'h04;
    step(150);
    cmp("ch2 kept", ST_GROUND_SHORT, st[8:6]);
    rd = 2'h1;
    step(1);
    rd = 2'h0;
    step(1);
    cmp("status after read", 18'h36DFF, st);
  endtask
  task automatic t_short;
    par = 6'h01;
    gcmd = 6'h02;
    wait_for(1, 0, 3'h1);
    step(100);
    cmp("ch0 while blanking", ST_NOT_COMPLETE, st[2:0]);
    wait_for(0, 0, ST_ON_NO_SHORT);
    wait_for(0, 1, ST_SHORTED_LOAD);
    step(2);
    cmp("latched gates", 18'h00001, gate);
    cmp("flag enable", 1'b0, fl_oe_n);
  endtask
  task automatic t_pulse;
    pulse(6'h02);
    cmp("skipped pulse gate", 18'h00001, gate);
    rd = 2'h1;
    step(1);
    rd = 2'h0;
    step(200);
    pulse(6'h02);
    cmp("pulsed gate", 18'h00003, gate);
    wait_for(0, 1, ST_SHORTED_LOAD);
    step(80);
    cmp("gate after pulse", 18'h00001, gate);
  endtask
  task automatic t_disable;
    dis = 1'b1;
    rmode = 6'h02;
    step(8);
    cmp("gates disabled", 18'h00000, gate);
    cmp("status kept", {ST_OFF_NO_FAULT, ST_OFF_NO_FAULT, ST_OFF_NO_FAULT, ST_NOT_COMPLETE,
        ST_SHORTED_LOAD, ST_NOT_COMPLETE}, st);
    dis = 1'b0;
    wait_for(1, 1, 3'h1);
    wait_for(1, 1, 3'h0);
    step(30);
    cmp("retry hold", 18'h00000, {17'h00000, gate[1]});
    wait_for(1, 1, 3'h1);
  endtask
  initial begin
    step(6);
    rst_b_i = 1'b1;
    t_start();
    t_priority();
    t_short();
    t_pulse();
    t_disable();
    conclude();
  end
endmodule
`default_nettype wire
